// ===== hw/vsd_cfg.svh
`ifndef VSD_CFG_SVH
`define VSD_CFG_SVH
// Return handle width and field place in header dwords 0 and 1
`define VSD_HW 12
`define VSD_HDL_W 16
// Scratch size code: header dword 3, bits 3:0, largest code
`define VSD_SCR_DW 3
`define VSD_SCR_MAX 4'hb
// Push constant buffers and their summed limit in registers
`define VSD_PC_BUFS 4
`define VSD_PC_MAX 6'h20
// Idle cycles a lone miss waits for a partner
`define VSD_PAIR_WAIT 3'h4
// Counter reset value
`define VSD_CNT_RST 64'h0
`endif

// ===== hw/vsd_pkg.sv
`default_nettype none
`include "vsd_cfg.svh"
package vsd_pkg;
    typedef enum logic [2:0] {VSD_COLLECT, VSD_WAIT, VSD_EMIT0, VSD_EMIT1} vsd_state_t;
    typedef enum logic [1:0] {VSD_P_IDLE, VSD_P_SEND, VSD_P_FETCH} vsd_pstate_t;
    typedef struct packed {
        logic valid;
        logic shade;
        logic [`VSD_HW-1:0] src;
        logic [`VSD_HW-1:0] dst;
        logic [4:0] kind;
        logic pbeg;
        logic pend;
    } vsd_slot_t;
endpackage
`default_nettype wire

// ===== hw/vsd_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "vsd_cfg.svh"
// Thread dispatch request between sequencer and payload builder
interface vsd_if;
    logic start;
    logic [1:0] mask;
    logic [`VSD_HW-1:0] h0;
    logic [`VSD_HW-1:0] h1;
    logic [`VSD_HW-1:0] src0;
    logic [`VSD_HW-1:0] src1;
    logic done;
    modport ctl (output start, output mask, output h0, output h1, output src0, output src1, input done);
    modport pay (input start, input mask, input h0, input h1, input src0, input src1, output done);
endinterface
`default_nettype wire

// ===== hw/vsd_stats.sv
`timescale 1ns/1ps
`default_nettype none
`include "vsd_cfg.svh"
module vsd_stats #(
    parameter int CNT_W = 64
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic stats_on,
    input wire logic [1:0] ev,
    output logic [CNT_W-1:0] cnt
);
    generate
        if (CNT_W < 8 || CNT_W > 64) begin : g_chk
            $error("vsd_stats: CNT_W out of range");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // Add dispatched vertices, and vertices passed with shading off, only while statistics are on
    assign cnt_next = cnt_reg + {{(CNT_W-2){1'b0}}, ev};
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= CNT_W'(`VSD_CNT_RST);
        end else if (stats_on) begin
            cnt_reg <= cnt_next;
        end
    end
    assign cnt = cnt_reg;

    property p_cnt_step;
        @(posedge clk_sys) disable iff (!nrst)
        stats_on |=> cnt == $past(cnt) + {{(CNT_W-2){1'b0}}, $past(ev)};
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count step wrong");

    property p_cnt_hold;
        @(posedge clk_sys) disable iff (!nrst)
        !stats_on |=> $stable(cnt);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved while off");
endmodule
`default_nettype wire

// ===== hw/vsd_payload.sv
`timescale 1ns/1ps
`default_nettype none
`include "vsd_cfg.svh"
module vsd_payload #(
    parameter int HW = `VSD_HW
) (
    input wire logic clk_sys,
    input wire logic nrst,
    vsd_if.pay req,
    input wire logic [3:0] scratch_code,
    input wire logic [5:0] entry_rd_off,
    input wire logic [5:0] entry_rd_len,
    input wire logic [3:0] pcb_en,
    input wire logic [19:0] pcb_len,
    output logic pc_rd_req,
    output logic [4:0] pc_rd_idx,
    input wire logic pc_rd_valid,
    input wire logic [255:0] pc_rd_data,
    output logic ve_rd_req,
    output logic [HW-1:0] ve_rd_addr0,
    output logic [HW-1:0] ve_rd_addr1,
    input wire logic ve_rd_valid,
    input wire logic [127:0] ve_rd_data0,
    input wire logic [127:0] ve_rd_data1,
    output logic thr_valid,
    input wire logic thr_ready,
    output logic [255:0] thr_data,
    output logic thr_first,
    output logic thr_last,
    output logic [1:0] thr_mask
);
    generate
        if (HW > `VSD_HDL_W) begin : g_chk
            $error("vsd_payload: handle wider than its field");
        end
    endgenerate

    // Registers of constants: each enabled buffer gives its length plus one
    function automatic logic [5:0] pc_sum(input logic [3:0] en, input logic [19:0] len);
        logic [5:0] s;
        s = 6'h0;
        for (int i = 0; i < `VSD_PC_BUFS; i++) begin
            if (en[i]) begin
                s = s + {1'b0, len[5*i +: 5]} + 6'h1;
            end
        end
        return s;
    endfunction

    // Entry row address: source handle plus read offset plus row
    function automatic logic [HW-1:0] ve_addr(input logic [HW-1:0] b, input logic [5:0] o, input logic [5:0] r);
        return b + HW'(o) + HW'(r);
    endfunction

    vsd_pkg::vsd_pstate_t st_reg;
    logic [5:0] pc_cnt_reg;
    logic [5:0] pc_tot_reg;
    logic [5:0] ve_cnt_reg;
    logic [HW-1:0] src0_reg;
    logic [HW-1:0] src1_reg;
    logic done_reg;
    logic [255:0] hdr;
    logic [5:0] pc_total;
    logic more_pc;

    // Header: handles in dwords 0/1, dword 2 zero, scratch code in dword 3
    assign hdr = {128'h0, 28'h0, scratch_code, 32'h0, 16'h0, {(`VSD_HDL_W-HW){1'b0}}, req.h1,
                  16'h0, {(`VSD_HDL_W-HW){1'b0}}, req.h0};
    assign pc_total = pc_sum(pcb_en, pcb_len);
    assign more_pc = pc_cnt_reg < pc_tot_reg;

    // Header, then constants, then vertex rows
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= vsd_pkg::VSD_P_IDLE;
            {pc_cnt_reg, pc_tot_reg, ve_cnt_reg, src0_reg, src1_reg} <= '0;
            {thr_valid, thr_data, thr_first, thr_last, thr_mask} <= '0;
            {pc_rd_req, pc_rd_idx, ve_rd_req, ve_rd_addr0, ve_rd_addr1, done_reg} <= '0;
        end else begin
            pc_rd_req <= 1'b0;
            ve_rd_req <= 1'b0;
            done_reg <= 1'b0;
            case (st_reg)
                vsd_pkg::VSD_P_IDLE: begin
                    if (req.start) begin
                        thr_data <= hdr;
                        thr_valid <= 1'b1;
                        thr_first <= 1'b1;
                        thr_mask <= req.mask;
                        thr_last <= (pc_total == 6'h0) && (entry_rd_len == 6'h0);
                        pc_tot_reg <= pc_total;
                        pc_cnt_reg <= 6'h0;
                        ve_cnt_reg <= 6'h0;
                        src0_reg <= req.src0;
                        src1_reg <= req.src1;
                        st_reg <= vsd_pkg::VSD_P_SEND;
                    end
                end
                vsd_pkg::VSD_P_SEND: begin
                    if (thr_ready) begin
                        thr_valid <= 1'b0;
                        thr_first <= 1'b0;
                        if (thr_last) begin
                            done_reg <= 1'b1;
                            st_reg <= vsd_pkg::VSD_P_IDLE;
                        end else if (more_pc) begin
                            pc_rd_req <= 1'b1;
                            pc_rd_idx <= pc_cnt_reg[4:0];
                            st_reg <= vsd_pkg::VSD_P_FETCH;
                        end else begin
                            ve_rd_req <= 1'b1;
                            ve_rd_addr0 <= ve_addr(src0_reg, entry_rd_off, ve_cnt_reg);
                            ve_rd_addr1 <= ve_addr(src1_reg, entry_rd_off, ve_cnt_reg);
                            st_reg <= vsd_pkg::VSD_P_FETCH;
                        end
                    end
                end
                vsd_pkg::VSD_P_FETCH: begin
                    if (more_pc && pc_rd_valid) begin
                        thr_data <= pc_rd_data;
                        thr_valid <= 1'b1;
                        thr_last <= (pc_cnt_reg + 6'h1 == pc_tot_reg) && (entry_rd_len == 6'h0);
                        pc_cnt_reg <= pc_cnt_reg + 6'h1;
                        st_reg <= vsd_pkg::VSD_P_SEND;
                    end else if (!more_pc && ve_rd_valid) begin
                        thr_data <= {ve_rd_data1, ve_rd_data0};
                        thr_valid <= 1'b1;
                        thr_last <= ve_cnt_reg + 6'h1 == entry_rd_len;
                        ve_cnt_reg <= ve_cnt_reg + 6'h1;
                        st_reg <= vsd_pkg::VSD_P_SEND;
                    end
                end
                default: st_reg <= vsd_pkg::VSD_P_IDLE;
            endcase
        end
    end
    assign req.done = done_reg;

    property p_hdr_zero;
        @(posedge clk_sys) disable iff (!nrst)
        thr_valid && thr_first |-> thr_data[95:64] == 32'h0 && thr_data[99:96] == scratch_code;
    endproperty
    a_hdr_zero: assert property (p_hdr_zero) else $error("header dword 2 or scratch wrong");

    property p_single_same;
        @(posedge clk_sys) disable iff (!nrst)
        thr_valid && thr_first && thr_mask == 2'b01 |-> thr_data[15:0] == thr_data[47:32];
    endproperty
    a_single_same: assert property (p_single_same) else $error("lone vertex handles differ");
endmodule
`default_nettype wire

// ===== hw/vsd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vsd_cfg.svh"
module vsd_top #(
    parameter int HW = `VSD_HW,
    parameter int CNT_W = 64
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic shading_on,
    input wire logic stats_on,
    input wire logic [3:0] scratch_code,
    input wire logic [5:0] entry_rd_off,
    input wire logic [5:0] entry_rd_len,
    input wire logic [3:0] pcb_en,
    input wire logic [19:0] pcb_len,
    input wire logic flush_req,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_hit,
    input wire logic [HW-1:0] in_src,
    input wire logic [HW-1:0] in_dst,
    input wire logic [4:0] in_kind,
    input wire logic in_pbeg,
    input wire logic in_pend,
    output logic out_valid,
    input wire logic out_ready,
    output logic [HW-1:0] out_handle,
    output logic [4:0] out_kind,
    output logic out_pbeg,
    output logic out_pend,
    output logic pc_rd_req,
    output logic [4:0] pc_rd_idx,
    input wire logic pc_rd_valid,
    input wire logic [255:0] pc_rd_data,
    output logic ve_rd_req,
    output logic [HW-1:0] ve_rd_addr0,
    output logic [HW-1:0] ve_rd_addr1,
    input wire logic ve_rd_valid,
    input wire logic [127:0] ve_rd_data0,
    input wire logic [127:0] ve_rd_data1,
    output logic thr_valid,
    input wire logic thr_ready,
    output logic [255:0] thr_data,
    output logic thr_first,
    output logic thr_last,
    output logic [1:0] thr_mask,
    output logic [CNT_W-1:0] shader_invocation_counter
);
    generate
        if (HW != `VSD_HW) begin : g_chk
            $error("vsd_top: HW must match the slot layout");
        end
    endgenerate

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    vsd_pkg::vsd_state_t state_reg;
    vsd_pkg::vsd_slot_t s0_reg;
    vsd_pkg::vsd_slot_t s1_reg;
    vsd_pkg::vsd_slot_t out_reg;
    vsd_pkg::vsd_slot_t in_slot;
    logic in_ready_reg;
    logic [2:0] wait_cnt_reg;
    logic start_reg;
    logic [1:0] dmask_reg;
    logic [HW-1:0] dh0_reg;
    logic [HW-1:0] dh1_reg;
    logic [HW-1:0] ds0_reg;
    logic [HW-1:0] ds1_reg;
    logic acc;
    logic go_pass;
    logic go_pair;
    logic go_single;
    logic lone_due;
    logic [1:0] cnt_ev;

    vsd_if disp ();

    // ------------------------------------------------------------
    // Decode of the incoming vertex
    // ------------------------------------------------------------
    // Hits and unshaded vertices carry their reference straight through
    assign in_slot = '{valid: 1'b1,
                       shade: shading_on && !in_hit,
                       src: in_src,
                       dst: shading_on ? in_dst : in_src,
                       kind: in_kind,
                       pbeg: in_pbeg,
                       pend: in_pend};
    assign acc = in_valid && in_ready_reg && (state_reg == vsd_pkg::VSD_COLLECT);
    // Pending miss with nothing to pair: flush or idle wait ran out
    assign lone_due = !acc && (state_reg == vsd_pkg::VSD_COLLECT) && s0_reg.valid
                      && (flush_req || wait_cnt_reg == `VSD_PAIR_WAIT);
    assign go_pass = acc && !in_slot.shade && !s0_reg.valid;
    assign go_pair = acc && in_slot.shade && s0_reg.valid;
    // A hit behind a lone miss forces the miss out first to keep order
    assign go_single = (acc && !in_slot.shade && s0_reg.valid) || lone_due;

    // Invocation events: vertices sent to threads, or passed with shading off
    assign cnt_ev = {go_pair, 1'b0} + {1'b0, go_single} + {1'b0, acc && !shading_on};

    // ------------------------------------------------------------
    // Pairing, dispatch and in-order emission
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= vsd_pkg::VSD_COLLECT;
            s0_reg <= '0;
            s1_reg <= '0;
            out_reg <= '0;
            in_ready_reg <= 1'b0;
            wait_cnt_reg <= 3'h0;
            start_reg <= 1'b0;
            {dmask_reg, dh0_reg, dh1_reg, ds0_reg, ds1_reg} <= '0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                vsd_pkg::VSD_COLLECT: begin
                    in_ready_reg <= !(go_pass || go_pair || go_single);
                    if (go_pass) begin
                        out_reg <= in_slot;
                        state_reg <= vsd_pkg::VSD_EMIT0;
                    end else if (go_pair || go_single) begin
                        start_reg <= 1'b1;
                        dmask_reg <= go_pair ? 2'b11 : 2'b01;
                        dh0_reg <= s0_reg.dst;
                        dh1_reg <= go_pair ? in_slot.dst : s0_reg.dst;
                        ds0_reg <= s0_reg.src;
                        ds1_reg <= go_pair ? in_slot.src : s0_reg.src;
                        if (acc) begin
                            s1_reg <= in_slot;
                        end
                        state_reg <= vsd_pkg::VSD_WAIT;
                    end else if (acc) begin
                        s0_reg <= in_slot;
                        wait_cnt_reg <= 3'h0;
                    end else if (s0_reg.valid) begin
                        wait_cnt_reg <= wait_cnt_reg + 3'h1;
                    end
                end
                vsd_pkg::VSD_WAIT: begin
                    if (disp.done) begin
                        out_reg <= s0_reg;
                        state_reg <= vsd_pkg::VSD_EMIT0;
                    end
                end
                vsd_pkg::VSD_EMIT0: begin
                    if (out_ready) begin
                        if (s1_reg.valid) begin
                            out_reg <= s1_reg;
                            state_reg <= vsd_pkg::VSD_EMIT1;
                        end else begin
                            out_reg.valid <= 1'b0;
                            s0_reg <= '0;
                            in_ready_reg <= 1'b1;
                            state_reg <= vsd_pkg::VSD_COLLECT;
                        end
                    end
                end
                vsd_pkg::VSD_EMIT1: begin
                    if (out_ready) begin
                        out_reg.valid <= 1'b0;
                        s0_reg <= '0;
                        s1_reg <= '0;
                        in_ready_reg <= 1'b1;
                        state_reg <= vsd_pkg::VSD_COLLECT;
                    end
                end
                default: state_reg <= vsd_pkg::VSD_COLLECT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs and dispatch request
    // ------------------------------------------------------------
    // Tags copied untouched from the slot flops
    assign in_ready = in_ready_reg;
    assign out_valid = out_reg.valid;
    assign out_handle = out_reg.dst;
    assign out_kind = out_reg.kind;
    assign out_pbeg = out_reg.pbeg;
    assign out_pend = out_reg.pend;
    assign disp.start = start_reg;
    assign disp.mask = dmask_reg;
    assign disp.h0 = dh0_reg;
    assign disp.h1 = dh1_reg;
    assign disp.src0 = ds0_reg;
    assign disp.src1 = ds1_reg;

    // Payload builder and thread port
    vsd_payload #(.HW(HW)) u_payload (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .req(disp.pay),
        .scratch_code(scratch_code),
        .entry_rd_off(entry_rd_off),
        .entry_rd_len(entry_rd_len),
        .pcb_en(pcb_en),
        .pcb_len(pcb_len),
        .pc_rd_req(pc_rd_req),
        .pc_rd_idx(pc_rd_idx),
        .pc_rd_valid(pc_rd_valid),
        .pc_rd_data(pc_rd_data),
        .ve_rd_req(ve_rd_req),
        .ve_rd_addr0(ve_rd_addr0),
        .ve_rd_addr1(ve_rd_addr1),
        .ve_rd_valid(ve_rd_valid),
        .ve_rd_data0(ve_rd_data0),
        .ve_rd_data1(ve_rd_data1),
        .thr_valid(thr_valid),
        .thr_ready(thr_ready),
        .thr_data(thr_data),
        .thr_first(thr_first),
        .thr_last(thr_last),
        .thr_mask(thr_mask)
    );

    // Invocation counter
    vsd_stats #(.CNT_W(CNT_W)) u_stats (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .stats_on(stats_on),
        .ev(cnt_ev),
        .cnt(shader_invocation_counter)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_pass_out;
        @(posedge clk_sys) disable iff (!nrst)
        go_pass |=> out_valid && out_handle == $past(in_slot.dst) && out_kind == $past(in_kind)
                    && out_pbeg == $past(in_pbeg) && out_pend == $past(in_pend);
    endproperty
    a_pass_out: assert property (p_pass_out) else $error("pass-through reference wrong");

    property p_hit_nocount;
        @(posedge clk_sys) disable iff (!nrst)
        acc && shading_on && in_hit && !s0_reg.valid |-> cnt_ev == 2'h0;
    endproperty
    a_hit_nocount: assert property (p_hit_nocount) else $error("cache hit counted");

    property p_off_count;
        @(posedge clk_sys) disable iff (!nrst)
        acc && !shading_on && !s0_reg.valid |-> cnt_ev == 2'h1;
    endproperty
    a_off_count: assert property (p_off_count) else $error("unshaded vertex not counted once");

    property p_pair_count;
        @(posedge clk_sys) disable iff (!nrst)
        disp.start |-> $past(cnt_ev) == (disp.mask == 2'b11 ? 2'h2 : 2'h1) || $past(!shading_on);
    endproperty
    a_pair_count: assert property (p_pair_count) else $error("dispatch count wrong");

    property p_lone_flush;
        @(posedge clk_sys) disable iff (!nrst)
        lone_due |=> disp.start && disp.mask == 2'b01 && disp.h0 == disp.h1;
    endproperty
    a_lone_flush: assert property (p_lone_flush) else $error("lone vertex not dispatched");

    property p_hit_order;
        @(posedge clk_sys) disable iff (!nrst)
        acc && !in_slot.shade && s0_reg.valid |=> (disp.start && disp.mask == 2'b01 && !out_valid
            && state_reg == vsd_pkg::VSD_WAIT) ##1 (state_reg == vsd_pkg::VSD_WAIT && !out_valid);
    endproperty
    a_hit_order: assert property (p_hit_order) else $error("hit overtook pending miss");

    // Nothing leaves while a thread is still being fed
    property p_wait_quiet;
        @(posedge clk_sys) disable iff (!nrst)
        state_reg == vsd_pkg::VSD_WAIT |-> !out_valid;
    endproperty
    a_wait_quiet: assert property (p_wait_quiet) else $error("output during dispatch");
endmodule
`default_nettype wire

// ===== verif/vsd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: constant and entry reads, thread sink
module vsd_far_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic slow,
    input wire logic pc_rd_req,
    input wire logic [4:0] pc_rd_idx,
    input wire logic ve_rd_req,
    input wire logic [11:0] ve_rd_addr0,
    input wire logic [11:0] ve_rd_addr1,
    output logic pc_rd_valid,
    output logic [255:0] pc_rd_data,
    output logic ve_rd_valid,
    output logic [127:0] ve_rd_data0,
    output logic [127:0] ve_rd_data1,
    output logic thr_ready
);
    logic pc_p, ve_p, tgl;
    logic [1:0] wt;
    logic [4:0] idx;
    logic [11:0] a0, a1;
    // Sink thread: no bypassing writes, no extra handles, ends on its last beat; slow takes every other beat
    assign thr_ready = !slow || tgl;
    // One answer per request, prompt or late; idle data keeps toggling
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            {pc_p, ve_p, tgl, wt, idx, a0, a1, pc_rd_valid, ve_rd_valid} <= '0;
            {pc_rd_data, ve_rd_data0, ve_rd_data1} <= '0;
        end else begin
            tgl <= ~tgl;
            pc_rd_valid <= 1'b0;
            ve_rd_valid <= 1'b0;
            pc_rd_data <= ~pc_rd_data;
            ve_rd_data0 <= ~ve_rd_data0;
            ve_rd_data1 <= ~ve_rd_data1;
            if (pc_rd_req || ve_rd_req) begin
                pc_p <= pc_rd_req;
                ve_p <= ve_rd_req;
                idx <= pc_rd_idx;
                a0 <= ve_rd_addr0;
                a1 <= ve_rd_addr1;
                wt <= slow ? 2'h3 : 2'h0;
            end else if (wt != 2'h0) begin
                wt <= wt - 2'h1;
            end else if (pc_p || ve_p) begin
                {pc_p, ve_p, pc_rd_valid, ve_rd_valid} <= {2'b00, pc_p, ve_p};
                pc_rd_data <= {8{27'h1234567, idx}};
                ve_rd_data0 <= {4{20'h0, a0}};
                ve_rd_data1 <= {4{20'h0, a1}};
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/vsd_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vsd_tb_top;
    logic clk_sys, nrst, slow, shading_on, stats_on, flush_req, in_valid, in_hit, in_pbeg, in_pend, out_ready;
    logic in_ready, out_valid, out_pbeg, out_pend, pc_rd_req, pc_rd_valid, ve_rd_req, ve_rd_valid;
    logic thr_valid, thr_ready, thr_first, thr_last;
    logic [3:0] scratch_code, pcb_en;
    logic [5:0] entry_rd_off, entry_rd_len;
    logic [19:0] pcb_len;
    logic [11:0] in_src, in_dst, out_handle, ve_rd_addr0, ve_rd_addr1;
    logic [4:0] in_kind, out_kind, pc_rd_idx;
    logic [255:0] pc_rd_data, thr_data;
    logic [127:0] ve_rd_data0, ve_rd_data1;
    logic [1:0] thr_mask, hmask;
    logic [63:0] shader_invocation_counter, c0;
    logic [255:0] beats[$];
    logic [18:0] outs[$];
    int n_errors = 0;
    int tests_run = 0;
    int lastpos;
    vsd_top vsd_top_i (.clk_sys, .nrst, .shading_on, .stats_on, .scratch_code, .entry_rd_off, .entry_rd_len,
        .pcb_en, .pcb_len, .flush_req, .in_valid, .in_ready, .in_hit, .in_src, .in_dst, .in_kind, .in_pbeg,
        .in_pend, .out_valid, .out_ready, .out_handle, .out_kind, .out_pbeg, .out_pend, .pc_rd_req, .pc_rd_idx,
        .pc_rd_valid, .pc_rd_data, .ve_rd_req, .ve_rd_addr0, .ve_rd_addr1, .ve_rd_valid, .ve_rd_data0,
        .ve_rd_data1, .thr_valid, .thr_ready, .thr_data, .thr_first, .thr_last, .thr_mask,
        .shader_invocation_counter);
    vsd_far_model vsd_far_model_i (.clk_sys, .nrst, .slow, .pc_rd_req, .pc_rd_idx, .ve_rd_req, .ve_rd_addr0,
        .ve_rd_addr1, .pc_rd_valid, .pc_rd_data, .ve_rd_valid, .ve_rd_data0, .ve_rd_data1, .thr_ready);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Collect thread beats and output references
    always @(posedge clk_sys) begin
        out_ready <= !slow || !out_ready;
        if (nrst && thr_valid && thr_ready) begin
            if (thr_first) beats.delete();
            if (thr_first) hmask = thr_mask;
            if (thr_last) lastpos = beats.size();
            beats.push_back(thr_data);
        end
        if (nrst && out_valid && out_ready) outs.push_back({out_kind, out_pbeg, out_pend, out_handle});
    end
    function automatic logic [127:0] ved(input logic [11:0] a);
        return {4{20'h0, a}};
    endfunction
    task automatic chk(input logic [255:0] g, input logic [255:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic send(input logic h, input logic [11:0] s, input logic [11:0] d);
        @(posedge clk_sys);
        in_valid <= 1'b1;
        in_hit <= h;
        in_src <= s;
        in_dst <= d;
        @(posedge clk_sys);
        while (in_ready !== 1'b1) @(posedge clk_sys);
        in_valid <= 1'b0;
    endtask
    task automatic wait_out(input int n);
        for (int i = 0; i < 300 && outs.size() < n; i++) @(posedge clk_sys);
        chk(outs.size(), n);
    endtask
    task automatic begin_case;
        outs.delete();
        c0 = shader_invocation_counter;
    endtask
    task automatic t_pass;
        begin_case();
        send(1'b0, 12'h011, 12'h0aa);
        wait_out(1);
        chk(outs[0], {5'h13, 2'b10, 12'h011});
        chk(shader_invocation_counter, c0 + 64'h1);
        stats_on <= 1'b0;
        send(1'b0, 12'h012, 12'h0ab);
        wait_out(2);
        chk(outs[1], {5'h13, 2'b10, 12'h012});
        chk(shader_invocation_counter, c0 + 64'h1);
        stats_on <= 1'b1;
    endtask
    task automatic t_pair;
        shading_on <= 1'b1;
        begin_case();
        send(1'b0, 12'h020, 12'h100);
        send(1'b0, 12'h030, 12'h140);
        wait_out(2);
        chk(beats[0][15:0], 12'h100);
        chk(beats[0][47:32], 12'h140);
        chk(beats[0][95:64], 32'h0);
        chk(beats[0][99:96], 4'hb);
        chk(hmask, 2'b11);
        chk(lastpos, 3);
        chk(beats[2], {8{27'h1234567, 5'h01}});
        chk(beats[3], {ved(12'h032), ved(12'h022)});
        chk({outs[0][11:0], outs[1][11:0]}, {12'h100, 12'h140});
        chk(shader_invocation_counter, c0 + 64'h2);
    endtask
    task automatic t_lone;
        slow <= 1'b1;
        flush_req <= 1'b1;
        begin_case();
        send(1'b0, 12'h050, 12'h180);
        wait_out(1);
        chk(beats[0][47:32], 12'h180);
        chk(hmask, 2'b01);
        chk(beats[3][127:0], ved(12'h052));
        chk(shader_invocation_counter, c0 + 64'h1);
        flush_req <= 1'b0;
        slow <= 1'b0;
    endtask
    task automatic t_hit;
        begin_case();
        send(1'b0, 12'h060, 12'h200);
        send(1'b1, 12'h070, 12'h1c0);
        wait_out(2);
        chk({outs[0][11:0], outs[1][11:0]}, {12'h200, 12'h1c0});
        chk(shader_invocation_counter, c0 + 64'h1);
    endtask
    task automatic end_sim;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {nrst, slow, shading_on, flush_req, in_valid, in_hit, in_src, in_dst, out_ready} <= '0;
        {stats_on, scratch_code, entry_rd_off, entry_rd_len, pcb_en, pcb_len} <= {5'h1b, 6'h2, 6'h1, 4'h1, 20'h1};
        {in_kind, in_pbeg, in_pend} <= {5'h13, 2'b10};
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_pass();
        t_pair();
        t_lone();
        t_hit();
        end_sim();
    end
    initial begin
        #100us;
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
